// ### rtl/ccrg_map.vh
`ifndef CCRG_MAP_VH
`define CCRG_MAP_VH

// =====================================================================
// Timing
// =====================================================================
`define CCRG_ACLK_PERIOD_NS      5

// =====================================================================
// Divider
// =====================================================================
`define CCRG_DIV_RATIO           2'd3
`define CCRG_DIV_HIGH_PHASE      2'd0
`define CCRG_DIV_HOLD_PHASE      2'd2
`define CCRG_DIV_LAST_PHASE      2'd2

// =====================================================================
// Register offsets (byte addresses)
// =====================================================================
`define CCRG_OFF_CTRL            4'h0
`define CCRG_OFF_STATUS          4'h4
`define CCRG_OFF_IDENT           4'h8

// =====================================================================
// Control fields
// =====================================================================
`define CCRG_CTRL_SOFT_RESET     0
`define CCRG_CTRL_SOFT_HOLD      1
`define CCRG_CTRL_RESET_VALUE    2'h0

// =====================================================================
// Status fields
// =====================================================================
`define CCRG_STAT_READY          0
`define CCRG_STAT_CPU_RESET      1
`define CCRG_STAT_CPU_CLK        2
`define CCRG_STAT_PERIPH_CLK     3
`define CCRG_STAT_SRC_SEL        4
`define CCRG_STAT_CNT_SYNC       5
`define CCRG_STAT_SYNC_MODE      6
`define CCRG_STAT_PHASE_LO       7

// Arbitrary value, names no maker or part.
`define CCRG_IDENT_VALUE         32'h0c1c_0001

`define CCRG_RESP_OKAY           2'h0
`define CCRG_RESP_SLVERR         2'h2

`endif

// ### rtl/ccrg_sync.v
// =====================================================================
// Two-stage synchroniser for a group of pin levels
// =====================================================================
module ccrg_sync #(
   parameter W = 1
) (
   input  wire         aclk,
   input  wire         aresetn,
   input  wire [W-1:0] ready_sync_select_n_in,
   output wire [W-1:0] sync_out
);

   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;

   // Only the second stage is ever read outside this module.
   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= ready_sync_select_n_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule

// ### rtl/ccrg_div3.v
`include "ccrg_map.vh"

// =====================================================================
// Divide-by-three phase counter
// =====================================================================
module ccrg_div3 (
   input  wire       aclk,
   input  wire       aresetn,
   input  wire       src_rise,
   input  wire       hold,
   output wire [1:0] phase,
   output wire       cpu_clk,
   output wire       cpu_clk_rise
);

   reg  [1:0] cnt_ff;
   reg        clk_ff;
   reg        rise_ff;
   reg  [1:0] nxt_cnt;
   wire       nxt_clk;

   always @* begin
      nxt_cnt = cnt_ff;
      if (hold)
         nxt_cnt = `CCRG_DIV_HOLD_PHASE;
      else if (src_rise) begin
         if (cnt_ff == `CCRG_DIV_LAST_PHASE)
            nxt_cnt = `CCRG_DIV_HIGH_PHASE;
         else
            nxt_cnt = cnt_ff + 2'd1;
      end
   end

   // High during one source period out of three.
   assign nxt_clk = (nxt_cnt == `CCRG_DIV_HIGH_PHASE);

   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff  <= `CCRG_DIV_HOLD_PHASE;
         clk_ff  <= 1'b0;
         rise_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         clk_ff  <= nxt_clk;
         rise_ff <= nxt_clk & ~clk_ff;
      end
   end

   assign phase        = cnt_ff;
   assign cpu_clk      = clk_ff;
   assign cpu_clk_rise = rise_ff;

endmodule

// ### rtl/ccrg_top.v
// Overview of operation
// - Each ready input counts only while its own active-low gate input is low.
// - Sync-select low: gated ready reaches the output through two clocked stages.
// - Sync-select high: gated ready reaches the output through one stage.
// - Ready output follows enabled inputs, changing only with the processor clock.
// - Source-select low: processor and peripheral clocks come from the crystal.
// - Source-select high: both clocks come from the external frequency input.
// - Processor clock is one third of the source, high one third.
// - Peripheral clock is half the processor clock, 50 percent duty.
// - Oscillator copy output shows the crystal signal undivided.
// - Reset request is sampled on processor clock, driven out active high.
// - Counter-sync high holds the divide counter; low lets it count.
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.

`include "ccrg_map.vh"

module ccrg_top (
   input  wire        aclk,
   input  wire        aresetn,

   // AXI4-Lite register port
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,

   // Pins
   input  wire        crystal_pin_a,
   output wire        crystal_pin_b,
   input  wire        external_freq_in,
   input  wire        freq_source_select,
   input  wire        counter_sync_in,
   input  wire        reset_request_n,
   input  wire        ready_sync_select_n,
   input  wire        bus_a_ready_in,
   input  wire        bus_b_ready_in,
   input  wire        bus_a_ready_gate_n,
   input  wire        bus_b_ready_gate_n,
   output wire        cpu_clk_out,
   output wire        periph_clk_out,
   output wire        oscillator_copy_out,
   output wire        ready_out,
   output wire        cpu_reset_out
);

   // ==================================================================
   // Pin synchronisation
   // ==================================================================
   localparam PIN_W = 10;

   wire [PIN_W-1:0] pin_raw;
   wire [PIN_W-1:0] pin_sync;

   assign pin_raw = {crystal_pin_a, external_freq_in, freq_source_select,
                     counter_sync_in, reset_request_n, ready_sync_select_n,
                     bus_a_ready_in, bus_b_ready_in,
                     bus_a_ready_gate_n, bus_b_ready_gate_n};

   ccrg_sync #(
      .W (PIN_W)
   ) u_pin_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .ready_sync_select_n_in (pin_raw),
      .sync_out (pin_sync)
   );

   wire xtal_s;
   wire efi_s;
   wire src_sel_s;
   wire cnt_sync_s;
   wire rst_req_n_s;
   wire one_stage_s;
   wire rdy_a_s;
   wire rdy_b_s;
   wire gate_a_n_s;
   wire gate_b_n_s;

   assign xtal_s      = pin_sync[9];
   assign efi_s       = pin_sync[8];
   assign src_sel_s   = pin_sync[7];
   assign cnt_sync_s  = pin_sync[6];
   assign rst_req_n_s = pin_sync[5];
   assign one_stage_s = pin_sync[4];
   assign rdy_a_s     = pin_sync[3];
   assign rdy_b_s     = pin_sync[2];
   assign gate_a_n_s  = pin_sync[1];
   assign gate_b_n_s  = pin_sync[0];

   // ==================================================================
   // Control register
   // ==================================================================
   reg  [1:0] ctrl_ff;
   wire       soft_reset;
   wire       soft_hold;

   assign soft_reset = ctrl_ff[`CCRG_CTRL_SOFT_RESET];
   assign soft_hold  = ctrl_ff[`CCRG_CTRL_SOFT_HOLD];

   // ==================================================================
   // Oscillator copy and crystal feedback
   // ==================================================================
   reg osc_copy_ff;
   reg xtal_drive_ff;

   always @(posedge aclk) begin
      if (!aresetn) begin
         osc_copy_ff   <= 1'b0;
         xtal_drive_ff <= 1'b1;
      end else begin
         osc_copy_ff   <= xtal_s;
         xtal_drive_ff <= ~xtal_s;
      end
   end

   // ==================================================================
   // Source selection and edge detection
   // ==================================================================
   reg  src_prev_ff;
   wire src_level;
   wire src_rise;

   // Switching the source mid-period can stretch or shorten one processor
   // clock phase; the divider never sees a runt edge because only the
   // sampled level is used.
   assign src_level = src_sel_s ? efi_s : xtal_s;
   assign src_rise  = src_level & ~src_prev_ff;

   always @(posedge aclk) begin
      if (!aresetn)
         src_prev_ff <= 1'b0;
      else
         src_prev_ff <= src_level;
   end

   // ==================================================================
   // Divide-by-three processor clock
   // ==================================================================
   wire [1:0] div_phase;
   wire       cpu_clk;
   wire       cpu_clk_rise;

   // Counter-sync is taken as a level; the far side keeps it aligned to the
   // external source so that several generators release on the same edge.
   ccrg_div3 u_div3 (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .src_rise     (src_rise),
      .hold         (cnt_sync_s | soft_hold),
      .phase        (div_phase),
      .cpu_clk      (cpu_clk),
      .cpu_clk_rise (cpu_clk_rise)
   );

   // ==================================================================
   // Peripheral clock
   // ==================================================================
   reg periph_clk_ff;

   always @(posedge aclk) begin
      if (!aresetn)
         periph_clk_ff <= 1'b0;
      else if (cpu_clk_rise)
         periph_clk_ff <= ~periph_clk_ff;
   end

   // ==================================================================
   // Ready path
   // ==================================================================
   wire gated_ready;
   reg  ready_stage_ff;
   reg  ready_ff;

   // Tied-low gates leave both ready inputs permanently honoured.
   assign gated_ready = (rdy_a_s & ~gate_a_n_s) | (rdy_b_s & ~gate_b_n_s);

   always @(posedge aclk) begin
      if (!aresetn) begin
         ready_stage_ff <= 1'b0;
         ready_ff       <= 1'b0;
      end else if (cpu_clk_rise) begin
         ready_stage_ff <= gated_ready;
         if (one_stage_s)
            ready_ff <= gated_ready;
         else
            ready_ff <= ready_stage_ff;
      end
   end

   // ==================================================================
   // Processor reset
   // ==================================================================
   reg cpu_reset_ff;

   // Held active through bus reset so the processor never runs on an
   // unsettled clock.
   always @(posedge aclk) begin
      if (!aresetn)
         cpu_reset_ff <= 1'b1;
      else if (cpu_clk_rise)
         cpu_reset_ff <= ~rst_req_n_s | soft_reset;
   end

   // ==================================================================
   // AXI4-Lite write channel
   // ==================================================================
   reg        awready_ff;
   reg        wready_ff;
   reg        bvalid_ff;
   reg  [1:0] bresp_ff;
   reg        aw_held_ff;
   reg        w_held_ff;
   reg  [3:0] aw_addr_ff;
   reg  [31:0] w_data_ff;
   reg  [3:0] w_strb_ff;

   wire aw_take;
   wire w_take;
   wire aw_have;
   wire w_have;
   wire [3:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire wr_do;

   assign aw_take = s_axi_awvalid & awready_ff;
   assign w_take  = s_axi_wvalid & wready_ff;
   assign aw_have = aw_held_ff | aw_take;
   assign w_have  = w_held_ff | w_take;
   assign wr_do   = aw_have & w_have & ~bvalid_ff;
   assign wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
   assign wr_data = w_held_ff ? w_data_ff : s_axi_wdata;
   assign wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb;

   always @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `CCRG_RESP_OKAY;
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
         aw_addr_ff <= 4'h0;
         w_data_ff  <= 32'h0000_0000;
         w_strb_ff  <= 4'h0;
         ctrl_ff    <= `CCRG_CTRL_RESET_VALUE;
      end else begin
         if (aw_take)
            aw_addr_ff <= s_axi_awaddr;
         if (w_take) begin
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         if (wr_do) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b1;
            if (wr_addr == `CCRG_OFF_CTRL) begin
               bresp_ff <= `CCRG_RESP_OKAY;
               if (wr_strb[0])
                  ctrl_ff <= wr_data[1:0];
            end else if (wr_addr == `CCRG_OFF_STATUS || wr_addr == `CCRG_OFF_IDENT)
               bresp_ff <= `CCRG_RESP_OKAY;
            else
               bresp_ff <= `CCRG_RESP_SLVERR;
         end else begin
            if (aw_take) begin
               aw_held_ff <= 1'b1;
               awready_ff <= 1'b0;
            end
            if (w_take) begin
               w_held_ff <= 1'b1;
               wready_ff <= 1'b0;
            end
         end
         if (bvalid_ff && s_axi_bready) begin
            bvalid_ff  <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
         end
      end
   end

   // ==================================================================
   // AXI4-Lite read channel
   // ==================================================================
   reg         arready_ff;
   reg         rvalid_ff;
   reg  [31:0] rdata_ff;
   reg  [1:0]  rresp_ff;
   reg  [31:0] nxt_rdata;
   reg  [1:0]  nxt_rresp;
   wire [31:0] status_word;

   assign status_word = {23'h0, div_phase, one_stage_s, cnt_sync_s, src_sel_s,
                         periph_clk_ff, cpu_clk, cpu_reset_ff, ready_ff};

   always @* begin
      nxt_rdata = 32'h0000_0000;
      nxt_rresp = `CCRG_RESP_OKAY;
      case (s_axi_araddr)
         `CCRG_OFF_CTRL:   nxt_rdata = {30'h0, ctrl_ff};
         `CCRG_OFF_STATUS: nxt_rdata = status_word;
         `CCRG_OFF_IDENT:  nxt_rdata = `CCRG_IDENT_VALUE;
         default:          nxt_rresp = `CCRG_RESP_SLVERR;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= `CCRG_RESP_OKAY;
      end else if (s_axi_arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rdata_ff   <= nxt_rdata;
         rresp_ff   <= nxt_rresp;
      end else if (rvalid_ff && s_axi_rready) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
      end
   end

   // ==================================================================
   // Outputs
   // ==================================================================
   assign s_axi_awready       = awready_ff;
   assign s_axi_wready        = wready_ff;
   assign s_axi_bvalid        = bvalid_ff;
   assign s_axi_bresp         = bresp_ff;
   assign s_axi_arready       = arready_ff;
   assign s_axi_rvalid        = rvalid_ff;
   assign s_axi_rdata         = rdata_ff;
   assign s_axi_rresp         = rresp_ff;
   assign crystal_pin_b       = xtal_drive_ff;
   assign oscillator_copy_out = osc_copy_ff;
   assign cpu_clk_out         = cpu_clk;
   assign periph_clk_out      = periph_clk_ff;
   assign ready_out           = ready_ff;
   assign cpu_reset_out       = cpu_reset_ff;

endmodule

// ### tb/ccrg_top_monitor.sv
// =====================================================================
// Pin checker for the processor clock, ready and reset outputs
// =====================================================================
module ccrg_top_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic crystal_pin_a,
   input wire logic crystal_pin_b,
   input wire logic counter_sync_in,
   input wire logic reset_request_n,
   input wire logic bus_a_ready_in,
   input wire logic bus_b_ready_in,
   input wire logic bus_a_ready_gate_n,
   input wire logic bus_b_ready_gate_n,
   input wire logic cpu_clk_out,
   input wire logic periph_clk_out,
   input wire logic oscillator_copy_out,
   input wire logic ready_out,
   input wire logic cpu_reset_out
);
   timeunit 1ns;
   timeprecision 100ps;

   logic       cq_ff;
   logic       rd_ff;
   logic       gq_ff;
   logic [1:0] gr_ff;
   logic [1:0] rr_ff;
   logic [2:0] hc_ff;
   logic [2:0] uc_ff;
   wire        rise  = cpu_clk_out & ~cq_ff;
   wire        gated = (bus_a_ready_in & ~bus_a_ready_gate_n) | (bus_b_ready_in & ~bus_b_ready_gate_n);

   // Ready and reset values are only judged after three processor clock rises, so that both
   // synchroniser depths have flushed whatever mode is selected.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cq_ff <= 1'b0;
         rd_ff <= 1'b0;
         gq_ff <= 1'b0;
         gr_ff <= 2'h0;
         rr_ff <= 2'h0;
         hc_ff <= 3'h0;
         uc_ff <= 3'h0;
      end else begin
         cq_ff <= cpu_clk_out;
         rd_ff <= rise;
         gq_ff <= gated;
         if (gated != gq_ff) gr_ff <= 2'h0;
         else if (rise && gr_ff != 2'h3) gr_ff <= gr_ff + 2'h1;
         if (reset_request_n) rr_ff <= 2'h0;
         else if (rise && rr_ff != 2'h3) rr_ff <= rr_ff + 2'h1;
         if (!counter_sync_in) hc_ff <= 3'h0;
         else if (hc_ff != 3'h7) hc_ff <= hc_ff + 3'h1;
         if (uc_ff != 3'h7) uc_ff <= uc_ff + 3'h1;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_periph; $rose(cpu_clk_out) |=> periph_clk_out != $past(periph_clk_out); endproperty
   a_periph: assert property (p_periph) else $error("peripheral clock did not toggle");
   property p_rdy_step; $changed(ready_out) |-> rd_ff; endproperty
   a_rdy_step: assert property (p_rdy_step) else $error("ready moved off the clock");
   property p_rst_step; $changed(cpu_reset_out) |-> rd_ff; endproperty
   a_rst_step: assert property (p_rst_step) else $error("reset moved off the clock");
   property p_rdy_val; rd_ff && gr_ff == 2'h3 |-> ready_out == gq_ff; endproperty
   a_rdy_val: assert property (p_rdy_val) else $error("ready value wrong");
   property p_rst_val; rd_ff && rr_ff == 2'h3 |-> cpu_reset_out; endproperty
   a_rst_val: assert property (p_rst_val) else $error("reset not driven");
   property p_osc; uc_ff == 3'h7 |-> oscillator_copy_out == $past(crystal_pin_a, 3); endproperty
   a_osc: assert property (p_osc) else $error("oscillator copy wrong");
   property p_xfb; uc_ff == 3'h7 |-> crystal_pin_b == !$past(crystal_pin_a, 3); endproperty
   a_xfb: assert property (p_xfb) else $error("crystal feedback wrong");
   property p_hold; hc_ff == 3'h7 |-> !cpu_clk_out; endproperty
   a_hold: assert property (p_hold) else $error("clock ran while held");
   property p_low; $fell(cpu_clk_out) |-> !cpu_clk_out [*8]; endproperty
   a_low: assert property (p_low) else $error("clock low phase too short");
endmodule

bind ccrg_top ccrg_top_monitor u_ccrg_top_monitor (.aclk, .aresetn, .crystal_pin_a, .crystal_pin_b, .counter_sync_in,
   .reset_request_n, .bus_a_ready_in, .bus_b_ready_in, .bus_a_ready_gate_n, .bus_b_ready_gate_n,
   .cpu_clk_out, .periph_clk_out, .oscillator_copy_out, .ready_out, .cpu_reset_out);

// ### tb/ccrg_cpu_side_model.sv
// =====================================================================
// Frequency sources and counter-sync driver on the processor side
// =====================================================================
module ccrg_cpu_side_model #(
   parameter int XTAL_HALF_NS = 20,
   parameter int EFI_HALF_NS  = 15
) (
   input  wire logic hold_req,
   output logic      crystal_pin_a,
   output logic      external_freq_in,
   output logic      counter_sync_in
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      crystal_pin_a = 1'b0;
      #1;
      forever #XTAL_HALF_NS crystal_pin_a = ~crystal_pin_a;
   end

   // Three source periods make one intended processor clock period.
   initial begin
      external_freq_in = 1'b0;
      #2;
      forever #EFI_HALF_NS external_freq_in = ~external_freq_in;
   end

   // Moving on the falling source edge keeps clear of the rising one.
   initial counter_sync_in = 1'b0;
   always @(negedge external_freq_in) counter_sync_in <= hold_req;
endmodule

// ### tb/ccrg_top_tb_top.sv
`include "ccrg_map.vh"

// =====================================================================
// Bench top
// =====================================================================
module ccrg_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic        aclk, aresetn, hold_req, reset_request_n, freq_source_select, ready_sync_select_n;
   logic        bus_a_ready_in, bus_b_ready_in, bus_a_ready_gate_n, bus_b_ready_gate_n;
   logic        crystal_pin_a, external_freq_in, counter_sync_in, cpu_clk_out, periph_clk_out;
   logic        oscillator_copy_out, ready_out, cpu_reset_out, s_axi_awvalid, s_axi_awready;
   logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [33:0] exp_q[$];
   int          mismatches = 0, cmp_count = 0, cyc = 0, seed = 32'h7374b687;

   ccrg_top u_ccrg_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .crystal_pin_a, .crystal_pin_b(), .external_freq_in, .freq_source_select,
      .counter_sync_in, .reset_request_n, .ready_sync_select_n, .bus_a_ready_in, .bus_b_ready_in,
      .bus_a_ready_gate_n, .bus_b_ready_gate_n, .cpu_clk_out, .periph_clk_out, .oscillator_copy_out,
      .ready_out, .cpu_reset_out);
   ccrg_cpu_side_model u_ccrg_cpu_side_model (.hold_req, .crystal_pin_a, .external_freq_in,
      .counter_sync_in);

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   // =====================================================================
   // Checking and closing
   // =====================================================================
   task automatic check(input string nm, input logic [33:0] e, input logic [33:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge aclk) begin
      if (s_axi_bvalid && s_axi_bready) check("bresp", exp_q.pop_front(), {s_axi_bresp, 32'h0});
      if (s_axi_rvalid && s_axi_rready) check("rdata", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
   end

   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         end_of_test();
      end
   end

   // =====================================================================
   // Drivers
   // =====================================================================
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw = 1'b1;
      logic w = 1'b1;
      exp_q.push_back({r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) aw = 1'b0;
         if (s_axi_wready) w = 1'b0;
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 1'b0;
      // An idle edge keeps a following call from reassigning these signals in the same step.
      @(posedge aclk);
   endtask

   task automatic axi_rd(input logic [3:0] a, input logic [33:0] e);
      exp_q.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   // Returns two cycles after a processor clock rise, once the outputs that follow it have landed.
   task automatic wait_rises(input int k);
      repeat (k) @(posedge cpu_clk_out);
      repeat (2) @(posedge aclk);
   endtask

   task automatic measure(input int p);
      int hi = 0;
      int ph = 0;
      @(posedge cpu_clk_out);
      repeat (6 * p) begin
         @(posedge aclk);
         hi += int'(cpu_clk_out);
         ph += int'(periph_clk_out);
      end
      check("cpu_high", 34'(2 * p), 34'(hi));
      check("periph_high", 34'(3 * p), 34'(ph));
   endtask

   // =====================================================================
   // Main sequence
   // =====================================================================
   initial begin
      logic [4:0] r;
      int n;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = {8'h0, 4'hf, 32'h0};
      {freq_source_select, hold_req, ready_sync_select_n, reset_request_n} = 4'h1;
      {bus_a_ready_in, bus_b_ready_in, bus_a_ready_gate_n, bus_b_ready_gate_n} = 4'h0;
      aresetn = 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(`CCRG_OFF_IDENT, {`CCRG_RESP_OKAY, `CCRG_IDENT_VALUE});
      axi_wr(`CCRG_OFF_CTRL, 32'h1, `CCRG_RESP_OKAY);
      axi_rd(`CCRG_OFF_CTRL, {`CCRG_RESP_OKAY, 32'h1});
      wait_rises(4);
      check("soft_reset", 34'h1, {33'h0, cpu_reset_out});
      axi_wr(`CCRG_OFF_CTRL, 32'h2, `CCRG_RESP_OKAY);
      n = 0;
      repeat (60) begin
         @(posedge aclk);
         n += int'(cpu_clk_out);
      end
      check("soft_hold", 34'h0, 34'(n));
      axi_wr(`CCRG_OFF_CTRL, 32'h0, `CCRG_RESP_OKAY);
      axi_wr(`CCRG_OFF_STATUS, 32'hff, `CCRG_RESP_OKAY);
      axi_wr(4'hc, 32'h1, `CCRG_RESP_SLVERR);
      axi_rd(4'hc, {`CCRG_RESP_SLVERR, 32'h0});
      measure(8);
      for (int v = 0; v < 2; v++) begin
         reset_request_n <= v[0];
         wait_rises(4);
         check("pin_reset", 34'(1 - v), {33'h0, cpu_reset_out});
      end
      repeat (12) begin
         r = 5'($random(seed));
         {ready_sync_select_n, bus_a_ready_in, bus_b_ready_in, bus_a_ready_gate_n, bus_b_ready_gate_n} <= r;
         wait_rises(4);
         check("ready", {33'h0, (r[3] & ~r[1]) | (r[2] & ~r[0])}, {33'h0, ready_out});
      end
      for (int m = 0; m < 2; m++) begin
         {bus_a_ready_gate_n, bus_b_ready_gate_n, bus_a_ready_in, bus_b_ready_in} <= 4'h0;
         ready_sync_select_n <= m[0];
         wait_rises(4);
         bus_a_ready_in <= 1'b1;
         n = 0;
         while (ready_out !== 1'b1) begin
            wait_rises(1);
            n++;
         end
         check("ready_lat", 34'(2 - m), 34'(n));
      end
      // The source is switched only while the divider is held, so no runt pulse reaches the clock.
      hold_req <= 1'b1;
      repeat (40) @(posedge aclk);
      freq_source_select <= 1'b1;
      n = 0;
      repeat (60) begin
         @(posedge aclk);
         n += int'(cpu_clk_out);
      end
      check("held_clk", 34'h0, 34'(n));
      hold_req <= 1'b0;
      n = 0;
      while (cpu_clk_out !== 1'b1 && n < 40) begin
         @(posedge aclk);
         n++;
      end
      check("resume", 34'h1, {33'h0, n < 24});
      measure(6);
      end_of_test();
   end
endmodule
